//--- rtl/prdtmr_map.svh
`ifndef PRDTMR_MAP_SVH
`define PRDTMR_MAP_SVH

// Byte offsets of the register words
`define PRDTMR_OFF_COUNTER   8'h00
`define PRDTMR_OFF_LIMIT     8'h04
`define PRDTMR_OFF_CONTROL   8'h08
`define PRDTMR_OFF_STATUS    8'h0c
`define PRDTMR_OFF_CLEAR     8'h10
`define PRDTMR_OFF_ENABLE    8'h14

// Control field positions
`define PRDTMR_POST_HI       6
`define PRDTMR_POST_LO       3
`define PRDTMR_RUN_BIT       2
`define PRDTMR_PRE_HI        1
`define PRDTMR_PRE_LO        0
`define PRDTMR_CTRL_W        7

// Status, clear and enable layout
`define PRDTMR_FLAG_BIT      0

// Reset values
`define PRDTMR_RST_COUNTER   8'h00
`define PRDTMR_RST_LIMIT     8'hff
`define PRDTMR_RST_CONTROL   7'h00
`define PRDTMR_RST_ENABLE    1'b0

`endif

//--- rtl/prdtmr_pkg.sv
package prdtmr_pkg;

    // Bus slave states, Gray coded along idle -> wait -> done
    typedef enum logic [1:0] {
        PRDTMR_ST_IDLE = 2'b00,
        PRDTMR_ST_WAIT = 2'b01,
        PRDTMR_ST_DONE = 2'b11
    } prdtmr_bus_e;

    typedef logic [7:0] prdtmr_byte_t;

    // Last prescaler count for a select code: 00 -> 0, 01 -> 3, 1x -> 15
    function automatic logic [3:0] prdtmr_pre_last(input logic [1:0] sel);
        logic [3:0] last;
        last = 4'h0;
        if (sel[1]) begin
            last = 4'hf;
        end else if (sel[0]) begin
            last = 4'h3;
        end
        return last;
    endfunction

endpackage

//--- rtl/prdtmr_scale_if.sv
`timescale 1ns/10ps
`default_nettype none

interface prdtmr_scale_if;
    logic       run;
    logic       clr;
    logic [1:0] pre_sel;
    logic [3:0] post_sel;
    logic       pre_tick;
    logic       match;
    logic       flag_pulse;

    modport ctrl (output run, clr, pre_sel, post_sel, match,
                  input  pre_tick, flag_pulse);
    modport pre  (input  run, clr, pre_sel, output pre_tick);
    modport post (input  clr, post_sel, match, output flag_pulse);
endinterface

`default_nettype wire

//--- rtl/prdtmr_prescale.sv
`timescale 1ns/10ps
`default_nettype none

module prdtmr_prescale
    import prdtmr_pkg::*;
(
    // Clock and reset
    input  wire logic      hclk,
    input  wire logic      hresetn,
    // Scaler link
    prdtmr_scale_if.pre    sc
);

    logic [3:0] pre_cnt_reg;
    logic       at_last;

    assign at_last = (pre_cnt_reg == prdtmr_pre_last(sc.pre_sel)); // RULE2

    // A clear in the same cycle swallows the tick so no stray increment
    assign sc.pre_tick = sc.run && !sc.clr && at_last; // RULE1

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_cnt_reg <= 4'h0; // RULE10
        end else if (sc.clr) begin
            pre_cnt_reg <= 4'h0; // RULE10
        end else if (sc.run) begin
            pre_cnt_reg <= at_last ? 4'h0 : pre_cnt_reg + 4'h1;
        end
    end

endmodule

`default_nettype wire

//--- rtl/prdtmr_postscale.sv
`timescale 1ns/10ps
`default_nettype none

module prdtmr_postscale
    import prdtmr_pkg::*;
(
    // Clock and reset
    input  wire logic      hclk,
    input  wire logic      hresetn,
    // Scaler link
    prdtmr_scale_if.post   sc
);

    logic [3:0] post_cnt_reg;
    logic       at_ratio;

    assign at_ratio      = (post_cnt_reg == sc.post_sel); // RULE5
    assign sc.flag_pulse = sc.match && !sc.clr && at_ratio; // RULE14

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            post_cnt_reg <= 4'h0; // RULE10
        end else if (sc.clr) begin
            post_cnt_reg <= 4'h0; // RULE10
        end else if (sc.match) begin
            post_cnt_reg <= at_ratio ? 4'h0 : post_cnt_reg + 4'h1; // RULE4
        end
    end

endmodule

`default_nettype wire

//--- rtl/prdtmr_top.sv
// How it works
// RULE1: Prescaler runs from the instruction clock; each prescaler pulse advances the counter.
// RULE2: Prescale code 00 divides by 1, 01 by 4, 1x by 16.
// RULE3: Counter equal to limit returns to zero on the next increment.
// RULE4: Each match advances the postscaler; its output sets the period event flag.
// RULE5: Postscale ratio is the four-bit code plus one, 1:1 to 1:16.
// RULE6: Control bits 6..3 postscale, bit 2 run enable, bits 1..0 prescale.
// RULE7: Counter advances only while run enable is one.
// RULE8: Counter and limit registers are fully readable and writable.
// RULE9: Reset loads counter with zero and limit with all ones.
// RULE10: Scaler counts clear on counter write, control write and reset.
// RULE11: A control write leaves the counter value untouched.
// RULE12: Control bit 7 ignores writes and reads as zero.
// RULE13: Period event flag stays set until software clears it.
// RULE14: Postscaler at its ratio gives a one-cycle set pulse and restarts.

`timescale 1ns/10ps
`default_nettype none
`include "prdtmr_map.svh"

module prdtmr_top
    import prdtmr_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave, address phase
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    // AHB-Lite slave, data phase
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Bus slave
    prdtmr_bus_e         state_reg;
    prdtmr_bus_e         state_next;
    logic [7:0]          addr_reg;
    logic                wr_reg;
    logic                mapped_reg;
    logic                hreadyout_reg;
    logic [31:0]         hrdata_reg;
    logic                hresp_reg;
    logic                irq_reg;

    // Timer registers
    prdtmr_byte_t        counter_reg;
    prdtmr_byte_t        limit_reg;
    logic [`PRDTMR_CTRL_W-1:0] control_reg;
    logic                flag_reg;
    logic                enable_reg;

    // Decode and datapath
    logic                take;
    logic                do_wr;
    logic                do_rd;
    logic                wr_counter;
    logic                wr_limit;
    logic                wr_control;
    logic                wr_clear;
    logic                wr_enable;
    logic                at_limit;
    logic [31:0]         rd_value;
    logic                irq_next;
    logic                flag_clr;

    prdtmr_scale_if      sc ();

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Every register is one aligned word, so the low address byte is
    // enough once the upper bits have been checked in the address phase
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] offset);
        return addr == offset;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave state

    // Every transfer gets exactly one wait state: the address is taken at
    // one edge, the register acts at the next, and hreadyout is high again
    // for the master to finish on the third. A new transfer may be taken
    // in the done state, so back to back accesses skip the idle state.
    // Sequential transfers are taken just like non-sequential ones.
    assign take = hsel && htrans[1] && hready;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PRDTMR_ST_IDLE: begin
                if (take) begin
                    state_next = PRDTMR_ST_WAIT;
                end
            end
            PRDTMR_ST_WAIT: begin
                state_next = PRDTMR_ST_DONE;
            end
            PRDTMR_ST_DONE: begin
                if (take) begin
                    state_next = PRDTMR_ST_WAIT;
                end else begin
                    state_next = PRDTMR_ST_IDLE;
                end
            end
            default: begin
                state_next = PRDTMR_ST_IDLE;
            end
        endcase
    end

    // Gray coded, so each step along idle, wait, done flips one bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= PRDTMR_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Address phase capture, one flop group per field
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 8'h00;
        end else if (take) begin
            addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= 1'b0;
        end else if (take) begin
            wr_reg <= hwrite;
        end
    end

    // Only word transfers to the low 256 bytes are mapped; anything else
    // ends OKAY but neither writes nor reads a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mapped_reg <= 1'b0;
        end else if (take) begin
            mapped_reg <= (haddr[31:8] == 24'h000000) &&
                          (haddr[1:0] == 2'b00) && (hsize == 3'h2);
        end
    end

    // One wait state lets the read data come straight from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
        end else begin
            hreadyout_reg <= (state_next != PRDTMR_ST_WAIT);
        end
    end

    // Every transfer ends OKAY; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
        end
    end

    assign do_wr = (state_reg == PRDTMR_ST_WAIT) && wr_reg && mapped_reg;
    assign do_rd = (state_reg == PRDTMR_ST_WAIT) && !wr_reg;

    // Writes act on the data-phase edge, with hwdata as it stands there
    assign wr_counter = do_wr && reg_hit(addr_reg, `PRDTMR_OFF_COUNTER);
    assign wr_limit   = do_wr && reg_hit(addr_reg, `PRDTMR_OFF_LIMIT);
    assign wr_control = do_wr && reg_hit(addr_reg, `PRDTMR_OFF_CONTROL);
    assign wr_clear   = do_wr && reg_hit(addr_reg, `PRDTMR_OFF_CLEAR);
    assign wr_enable  = do_wr && reg_hit(addr_reg, `PRDTMR_OFF_ENABLE);

    ////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb begin
        rd_value = 32'h00000000;
        if (mapped_reg) begin
            case (addr_reg)
                `PRDTMR_OFF_COUNTER: begin
                    rd_value[7:0] = counter_reg; // RULE8
                end
                `PRDTMR_OFF_LIMIT: begin
                    rd_value[7:0] = limit_reg; // RULE8
                end
                `PRDTMR_OFF_CONTROL: begin
                    // Bit 7 and above are never stored, so read as zero
                    rd_value[`PRDTMR_CTRL_W-1:0] = control_reg; // RULE12
                end
                `PRDTMR_OFF_STATUS: begin
                    rd_value[`PRDTMR_FLAG_BIT] = flag_reg;
                end
                `PRDTMR_OFF_ENABLE: begin
                    rd_value[`PRDTMR_FLAG_BIT] = enable_reg;
                end
                default: begin
                    rd_value = 32'h00000000;
                end
            endcase
        end
    end

    // The read word is latched on the data-phase edge, so hrdata is a flop
    // and holds its value until the next read completes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h00000000;
        end else if (do_rd) begin
            hrdata_reg <= rd_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and period registers

    // Bit 7 has no flop; whatever is written there is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_reg <= `PRDTMR_RST_CONTROL;
        end else if (wr_control) begin
            control_reg <= hwdata[`PRDTMR_CTRL_W-1:0]; // RULE12
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            limit_reg <= `PRDTMR_RST_LIMIT; // RULE9
        end else if (wr_limit) begin
            limit_reg <= hwdata[7:0]; // RULE8
        end
    end

    // Scaler wiring; a write to counter or control restarts both scalers
    assign sc.run      = control_reg[`PRDTMR_RUN_BIT]; // RULE7
    assign sc.pre_sel  = control_reg[`PRDTMR_PRE_HI:`PRDTMR_PRE_LO]; // RULE6
    assign sc.post_sel = control_reg[`PRDTMR_POST_HI:`PRDTMR_POST_LO]; // RULE6
    assign sc.clr      = wr_counter || wr_control; // RULE10

    ////////////////////////////////////////////////////////////////////////
    // Period counter

    // The prescaler tick is the only count event. The limit compare runs
    // every cycle but only acts on a tick, so the count sits at the limit
    // for one whole prescale period before it wraps to zero. A limit of
    // zero therefore matches on every tick.
    // Compared every cycle; the match only acts on an increment cycle
    assign at_limit = (counter_reg == limit_reg); // RULE3
    assign sc.match = sc.pre_tick && at_limit; // RULE4

    // Software write wins over a same-cycle increment; a control write
    // does not touch the count at all
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_reg <= `PRDTMR_RST_COUNTER; // RULE9
        end else if (wr_counter) begin
            counter_reg <= hwdata[7:0]; // RULE8
        end else if (sc.pre_tick) begin // RULE11
            if (at_limit) begin
                counter_reg <= 8'h00; // RULE3
            end else begin
                counter_reg <= counter_reg + 8'h01; // RULE1
            end
        end
    end

    prdtmr_prescale u_prescale (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sc      (sc)
    );

    prdtmr_postscale u_postscale (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sc      (sc)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event flag and interrupt

    // A clear needs a one in the flag's bit; other writes leave it set
    assign flag_clr = wr_clear && hwdata[`PRDTMR_FLAG_BIT]; // RULE13

    // Hardware set beats a software clear in the same cycle, so no
    // period event is lost while the handler acknowledges the last one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_reg <= 1'b0;
        end else if (sc.flag_pulse) begin
            flag_reg <= 1'b1; // RULE4
        end else if (flag_clr) begin
            flag_reg <= 1'b0; // RULE13
        end
    end

    // Enable shares the status layout; only the flag's bit is stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_reg <= `PRDTMR_RST_ENABLE;
        end else if (wr_enable) begin
            enable_reg <= hwdata[`PRDTMR_FLAG_BIT];
        end
    end

    // Interrupt follows the flag one cycle later to stay a pure flop
    assign irq_next = flag_reg && enable_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Every pin is driven straight from its flop
    assign hrdata    = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;
    assign irq       = irq_reg;

endmodule

`default_nettype wire

//--- bench/prdtmr_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module prdtmr_checker (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus request
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    // Bus answer and interrupt
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    logic take;
    logic wr;
    logic rd;
    assign take = hsel && htrans[1] && hready;
    assign wr   = take && hwrite;
    assign rd   = take && !hwrite && hsize == 3'h2;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////
    a_one_wait: assert property (
        take |=> !hreadyout ##1 hreadyout) else $error("bad wait state");
    a_ready_cause: assert property (
        !hreadyout |-> $past(take)) else $error("stray wait state");
    a_resp_okay: assert property (
        !hresp) else $error("response not okay");
    a_bit7_zero: assert property (
        rd && haddr == 32'h08 |-> ##2 hrdata[31:7] == 25'h0)
        else $error("control high bits set");
    a_count_width: assert property (
        rd && haddr == 32'h00 |-> ##2 hrdata[31:8] == 24'h0)
        else $error("counter wider than a byte");
    a_unmapped_zero: assert property (
        rd && haddr[31:8] != 24'h0 |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_reset: assert property (
        $rose(hresetn) |-> !irq) else $error("irq high after reset");
    // Only a software write may drop the level; the timer never clears it
    a_irq_fall: assert property (
        $fell(irq) |-> $past(wr, 3)) else $error("irq dropped by itself");
    cover property (wr);
    cover property ($rose(irq));
    cover property (rd && haddr == 32'h08);
endmodule

bind prdtmr_top prdtmr_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq)
);

`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "prdtmr_map.svh"

module tb_top;
    localparam logic [31:0] ad_cnt = 32'(`PRDTMR_OFF_COUNTER);
    localparam logic [31:0] ad_lim = 32'(`PRDTMR_OFF_LIMIT);
    localparam logic [31:0] ad_ctl = 32'(`PRDTMR_OFF_CONTROL);
    localparam logic [31:0] ad_sta = 32'(`PRDTMR_OFF_STATUS);
    localparam logic [31:0] ad_clr = 32'(`PRDTMR_OFF_CLEAR);
    localparam logic [31:0] ad_ena = 32'(`PRDTMR_OFF_ENABLE);
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [31:0] seed = 32'h1b;
    logic [31:0] v;
    logic [3:0]  q;
    int          cyc = 0;
    int          miscompares = 0;
    int          tests_run = 0;

    prdtmr_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq)
    );

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int exp_per(logic [1:0] p, logic [3:0] n,
                                   logic [7:0] l);
        return (int'(l) + 1) * (p[1] ? 16 : p[0] ? 4 : 1) * (int'(n) + 1);
    endfunction

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Every wait is bounded so a dead slave ends the run
    task automatic rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin
            miscompares++;
            end_of_test();
        end
    endtask

    task automatic bus(logic [31:0] a, logic w, logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        rdy();
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask

    task automatic wr(logic [31:0] a, logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rdc(string n, logic [31:0] a, logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, rnd(), r);
        chk(n, e, r);
    endtask

    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (irq !== 1'b1 && n < 5000);
        t = cyc;
        if (n >= 5000) begin
            miscompares++;
            end_of_test();
        end
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    // Interval between two flag events, so bus latency cancels out
    task automatic period(logic [1:0] p, logic [3:0] n, logic [7:0] l);
        int t0;
        int t1;
        wr(ad_ctl, 32'h0);
        wr(ad_clr, 32'h1);
        wr(ad_lim, {24'h0, l});
        wr(ad_cnt, 32'h0);
        wr(ad_ena, 32'h1);
        wr(ad_ctl, {25'h0, n, 1'b1, p});
        wait_irq(t0);
        wr(ad_clr, 32'h1);
        wait_irq(t1);
        chk("period", 32'(exp_per(p, n, l)), 32'(t1 - t0));
        $display("test period pre %0d post %0d done", p, n);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        rdc("count", ad_cnt, 32'h0);
        rdc("limit", ad_lim, 32'hff);
        rdc("control", ad_ctl, 32'h0);
        rdc("status", ad_sta, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            wr(ad_lim, v);
            wr(ad_cnt, v >> 8);
            wr(ad_ctl, (v | 32'h80) & 32'hfffffffb);
            rdc("count", ad_cnt, {24'h0, v[15:8]});
            rdc("limit", ad_lim, {24'h0, v[7:0]});
            rdc("control", ad_ctl, v & 32'h7b);
        end
        $display("test register access done");
        // Divide by 16: a counter write, then a control write, restart
        // the prescaler, so the first tick lands 16 edges after each
        wr(ad_lim, 32'hff);
        wr(ad_ctl, 32'h06);
        wr(ad_cnt, 32'h0);
        repeat (13) @(posedge hclk);
        rdc("restart", ad_cnt, 32'h0);
        rdc("restart", ad_cnt, 32'h1);
        wr(ad_ctl, 32'h06);
        repeat (13) @(posedge hclk);
        rdc("kept", ad_cnt, 32'h1);
        rdc("kept", ad_cnt, 32'h2);
        $display("test scaler restart done");
        for (int i = 0; i < 8; i++) begin
            q = (i == 0) ? 4'h0 : (i == 7) ? 4'hf : 4'(rnd());
            period(2'(i), q, 8'(5 + rnd() % 8));
        end
        wr(ad_ctl, 32'h0);
        bus(ad_cnt, 1'b0, 32'h0, v);
        repeat (20) @(posedge hclk);
        rdc("frozen", ad_cnt, v);
        wr(ad_sta, 32'h0);
        rdc("sticky", ad_sta, 32'h1);
        wr(ad_ena, 32'h0);
        @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(ad_clr, 32'h1);
        rdc("status", ad_sta, 32'h0);
        rdc("clear", ad_clr, 32'h0);
        rdc("unmapped", 32'h20, 32'h0);
        rdc("unmapped", 32'h100, 32'h0);
        $display("test flag and map done");
        wr(ad_ctl, 32'h4);
        repeat (10) @(posedge hclk);
        do_reset();
        rdc("count", ad_cnt, 32'h0);
        rdc("limit", ad_lim, 32'hff);
        $display("test second reset done");
        end_of_test();
    end
endmodule

`default_nettype wire
